// >>> rtl/fer_pkg.sv
// constants and types shared by the floating-point exception resolver
package fer_pkg;
    // exponent width of the datapath result, signed and unbiased
    localparam int EXP_W = 20;
    localparam int EXT_W = 80;
    localparam int SIG_W = 64;

    // destination formats
    typedef enum logic [1:0] {FMT_SINGLE, FMT_DOUBLE, FMT_EXT} fer_fmt_t;
    // kind of fault handed to dispatch
    typedef enum logic [2:0] {FLT_NONE, FLT_ZDIV, FLT_OVF, FLT_UNF, FLT_INX} fer_fault_t;

    // largest and smallest normalized unbiased exponents per format
    localparam logic signed [EXP_W-1:0] SGL_EMAX = 20'sh0007F;
    localparam logic signed [EXP_W-1:0] DBL_EMAX = 20'sh003FF;
    localparam logic signed [EXP_W-1:0] EXT_EMAX = 20'sh03FFF;
    localparam logic signed [EXP_W-1:0] SGL_EMIN = -20'sh0007E;
    localparam logic signed [EXP_W-1:0] DBL_EMIN = -20'sh003FE;
    localparam logic signed [EXP_W-1:0] EXT_EMIN = -20'sh03FFE;
    // exponent bias adjustment for the fault record, and extended bias
    localparam logic signed [EXP_W-1:0] BIAS_ADJ = 20'sh06000;
    localparam logic signed [EXP_W-1:0] EXT_BIAS = 20'sh03FFF;

    // significand masks: single keeps 24 bits (40 low zeroed), double 53
    localparam logic [SIG_W-1:0] SGL_SIG_MASK = 64'hFFFFFF0000000000;
    localparam logic [SIG_W-1:0] DBL_SIG_MASK = 64'hFFFFFFFFFFFFF800;

    // infinity encodings, right aligned in an 80-bit container, sign excluded
    localparam logic [EXT_W-1:0] SGL_INF = 80'h0000000000007F800000;
    localparam logic [EXT_W-1:0] DBL_INF = 80'h00007FF0000000000000;
    localparam logic [EXT_W-1:0] EXT_INF = 80'h7FFF8000000000000000;
    localparam int SGL_SIGN_BIT = 31;
    localparam int DBL_SIGN_BIT = 63;
    localparam int EXT_SIGN_BIT = 79;
    localparam logic [14:0] EXT_EXP_ONES = 15'h7FFF;
    localparam logic [SIG_W-1:0] INF_SIG = 64'h8000000000000000;

    // fault record flags byte: bit 1 marks a bias-adjusted exponent
    localparam int REC_BIAS_BIT = 1;

    // register offsets
    localparam logic [7:0] ARITH_CTRL_OFS = 8'h00;
    localparam logic [7:0] REC_LO_OFS = 8'h04;
    localparam logic [7:0] REC_MID_OFS = 8'h08;
    localparam logic [7:0] REC_HI_OFS = 8'h0C;
    localparam logic [7:0] LAST_FAULT_OFS = 8'h10;

    // arith_ctrl_word fields: flags [3:0], masks [11:8], rounding mode [17:16]
    localparam int FLAG_LSB = 0;
    localparam int MASK_LSB = 8;
    localparam int RMODE_LSB = 16;
    localparam int ZD_IDX = 0;
    localparam int OVF_IDX = 1;
    localparam int UNF_IDX = 2;
    localparam int INX_IDX = 3;
    localparam logic [3:0] MASK_RESET = 4'hF;
    localparam logic [1:0] RMODE_RESET = 2'h0;
endpackage

// >>> rtl/fer_resolver.sv
// floating-point exception resolver: zero-divide, overflow, underflow, inexact
// Operation
// - raise zero-divide when finite operands give an exactly non-finite result
// - masked zero-divide stores signed infinity and sets the zero-divide flag
// - unmasked zero-divide: no store, flag untouched, zero-divide fault
// - overflow when exact magnitude reaches 2^128, 2^1024 or 2^16384 by format
// - masked overflow stores rounded result and sets overflow flag
// - unmasked overflow: no store or flag; extended record rounded to destination precision
// - record exponent above 16383 is reduced by 24576, flags bit 1 set, overflow fault
// - scale overflow past adjusted range records signed infinity
// - float-to-integer conversion never raises floating overflow
// - underflow when nonzero result lies below smallest normalized destination magnitude
// - masked underflow denormalizes; exact stores quietly, inexact sets flag then inexact
// - unmasked underflow: no store or flag; extended record into fault area
// - record exponent below -16382 raised by 24576, flags bit 1 set, underflow fault
// - scale underflow past adjusted range records signed zero
// - inexact when rounding loses value or on masked overflow
// - masked inexact without unmasked over/underflow stores and sets inexact flag
// - unmasked lone inexact stores result then faults, flag not set
// - unmasked inexact with over/underflow: no store, record saved, inexact fault
// - tininess judged after rounding as underflow; accuracy loss reported as inexact
// - tiny inexact masked underflow: set underflow flag, then inexact fault or flag and store
// - flags are sticky; only a software write clears them
`timescale 1ns/1ps

module fer_resolver
(
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // one operation result from the datapath
    input wire logic i_op_valid,
    input wire fer_pkg::fer_fmt_t i_fmt,
    input wire logic i_div_zero,
    input wire logic i_f2i,
    input wire logic i_scale,
    input wire logic i_nonzero,
    input wire logic i_sign,
    input wire logic signed [fer_pkg::EXP_W-1:0] i_exp,
    input wire logic [fer_pkg::SIG_W-1:0] i_sig,
    input wire logic i_inexact,
    input wire logic [fer_pkg::EXT_W-1:0] i_dest_value,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // results
    output logic o_done,
    output logic o_dest_we,
    output logic [fer_pkg::EXT_W-1:0] o_dest_value,
    output logic o_fault,
    output fer_pkg::fer_fault_t o_fault_kind,
    output logic o_rec_we,
    output logic [fer_pkg::EXT_W-1:0] o_rec_value,
    output logic [7:0] o_rec_flags,
    output logic [1:0] o_round_mode
);
    import fer_pkg::*;

    logic [3:0] flags;
    logic [3:0] masks;
    logic [EXT_W-1:0] rec_value;
    logic [7:0] rec_flags;
    fer_fault_t last_fault;

    logic signed [EXP_W-1:0] emax;
    logic signed [EXP_W-1:0] emin;
    logic [SIG_W-1:0] sig_mask;
    logic [EXT_W-1:0] inf_value;
    logic ovf;
    logic unf;
    logic inx;
    logic signed [EXP_W-1:0] rec_exp;
    logic [EXP_W-1:0] rec_biased;
    logic rec_adj;
    logic [EXT_W-1:0] next_rec_value;
    logic [3:0] set_flags;
    logic next_dest_we;
    logic next_rec_we;
    fer_fault_t next_fault;

    // per-format thresholds, precision mask and infinity encoding
    always_comb
    begin
        unique case (i_fmt)
            FMT_SINGLE:
            begin
                emax = SGL_EMAX;
                emin = SGL_EMIN;
                sig_mask = SGL_SIG_MASK;
                inf_value = SGL_INF;
                inf_value[SGL_SIGN_BIT] = i_sign;
            end
            FMT_DOUBLE:
            begin
                emax = DBL_EMAX;
                emin = DBL_EMIN;
                sig_mask = DBL_SIG_MASK;
                inf_value = DBL_INF;
                inf_value[DBL_SIGN_BIT] = i_sign;
            end
            default:
            begin
                // unused format code is handled as extended
                emax = EXT_EMAX;
                emin = EXT_EMIN;
                sig_mask = {SIG_W{1'b1}};
                inf_value = EXT_INF;
                inf_value[EXT_SIGN_BIT] = i_sign;
            end
        endcase
    end

    // condition detection; zero-divide excludes the result-based conditions
    always_comb
    begin
        ovf = i_op_valid && !i_div_zero && !i_f2i && i_nonzero && (i_exp > emax);
        unf = i_op_valid && !i_div_zero && i_nonzero && (i_exp < emin) && !ovf;
        inx = i_op_valid && !i_div_zero && (i_inexact || (ovf && masks[OVF_IDX]));
    end

    // extended-format fault record with bias adjustment and massive cases
    always_comb
    begin
        rec_exp = i_exp;
        rec_adj = 1'b0;
        rec_biased = '0;
        next_rec_value = {i_sign, 15'h0000, i_sig & sig_mask};
        if (ovf && (i_exp > EXT_EMAX))
        begin
            rec_exp = i_exp - BIAS_ADJ;
            rec_adj = 1'b1;
        end
        if (unf && (i_exp < EXT_EMIN))
        begin
            rec_exp = i_exp + BIAS_ADJ;
            rec_adj = 1'b1;
        end
        rec_biased = rec_exp + EXT_BIAS;
        next_rec_value = {i_sign, rec_biased[14:0], i_sig & sig_mask};
        if (ovf && i_scale && (rec_exp > EXT_EMAX))
        begin
            next_rec_value = {i_sign, EXT_EXP_ONES, INF_SIG};
        end
        if (unf && i_scale && (rec_exp < EXT_EMIN))
        begin
            next_rec_value = {i_sign, {(EXT_W-1){1'b0}}};
        end
    end

    // resolution: store, record, flags and fault in fixed priority
    always_comb
    begin
        next_dest_we = 1'b0;
        next_rec_we = 1'b0;
        next_fault = FLT_NONE;
        set_flags = 4'h0;
        if (!i_op_valid)
        begin
            next_dest_we = 1'b0;
        end
        else if (i_div_zero)
        begin
            if (masks[ZD_IDX])
            begin
                next_dest_we = 1'b1;
                set_flags[ZD_IDX] = 1'b1;
            end
            else
            begin
                next_fault = FLT_ZDIV;
            end
        end
        else if (ovf && !masks[OVF_IDX])
        begin
            next_rec_we = 1'b1;
            next_fault = FLT_OVF;
        end
        else if (unf && !masks[UNF_IDX])
        begin
            next_rec_we = 1'b1;
            next_fault = FLT_UNF;
        end
        else if (unf)
        begin
            if (!i_inexact)
            begin
                next_dest_we = 1'b1;
            end
            else
            begin
                // underflow flag first, then inexact decision
                set_flags[UNF_IDX] = 1'b1;
                if (!masks[INX_IDX])
                begin
                    next_rec_we = 1'b1;
                    next_fault = FLT_INX;
                end
                else
                begin
                    set_flags[INX_IDX] = 1'b1;
                    next_dest_we = 1'b1;
                end
            end
        end
        else if (inx)
        begin
            if (masks[INX_IDX])
            begin
                next_dest_we = 1'b1;
                set_flags[INX_IDX] = 1'b1;
                set_flags[OVF_IDX] = ovf;
            end
            else if (ovf)
            begin
                set_flags[OVF_IDX] = 1'b1;
                next_rec_we = 1'b1;
                next_fault = FLT_INX;
            end
            else
            begin
                next_dest_we = 1'b1;
                next_fault = FLT_INX;
            end
        end
        else
        begin
            next_dest_we = 1'b1;
        end
    end

    // sticky flags: a software write replaces them, a set in the same cycle wins
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            flags <= 4'h0;
        end
        else if (i_wr && (i_addr == ARITH_CTRL_OFS))
        begin
            flags <= i_wdata[FLAG_LSB +: 4] | set_flags;
        end
        else
        begin
            flags <= flags | set_flags;
        end
    end

    // masks and rounding mode, software owned; all masked after reset
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            masks <= MASK_RESET;
            o_round_mode <= RMODE_RESET;
        end
        else if (i_wr && (i_addr == ARITH_CTRL_OFS))
        begin
            masks <= i_wdata[MASK_LSB +: 4];
            o_round_mode <= i_wdata[RMODE_LSB +: 2];
        end
    end

    // destination write path; infinity replaces the datapath value on zero-divide
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            o_done <= 1'b0;
            o_dest_we <= 1'b0;
            o_dest_value <= '0;
        end
        else
        begin
            o_done <= i_op_valid;
            o_dest_we <= next_dest_we;
            if (next_dest_we)
            begin
                o_dest_value <= i_div_zero ? inf_value : i_dest_value;
            end
        end
    end

    // fault record and fault pulse; record holds until the next fault that writes a record
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            o_fault <= 1'b0;
            o_fault_kind <= FLT_NONE;
            o_rec_we <= 1'b0;
            rec_value <= '0;
            rec_flags <= 8'h00;
            last_fault <= FLT_NONE;
        end
        else
        begin
            o_fault <= (next_fault != FLT_NONE);
            o_fault_kind <= next_fault;
            o_rec_we <= next_rec_we;
            if (next_rec_we)
            begin
                rec_value <= next_rec_value;
                rec_flags <= 8'h00;
                rec_flags[REC_BIAS_BIT] <= rec_adj;
            end
            if (next_fault != FLT_NONE)
            begin
                last_fault <= next_fault;
            end
        end
    end

    assign o_rec_value = rec_value;
    assign o_rec_flags = rec_flags;

    // read data one cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            o_rdata <= 32'h00000000;
        end
        else if (i_rd)
        begin
            unique case (i_addr)
                ARITH_CTRL_OFS:
                    o_rdata <= {14'h0000, o_round_mode, 4'h0, masks, 4'h0, flags};
                REC_LO_OFS:
                    o_rdata <= rec_value[31:0];
                REC_MID_OFS:
                    o_rdata <= rec_value[63:32];
                REC_HI_OFS:
                    o_rdata <= {8'h00, rec_flags, rec_value[79:64]};
                LAST_FAULT_OFS:
                    o_rdata <= {29'h00000000, last_fault};
                default:
                    o_rdata <= 32'h00000000;
            endcase
        end
        else
        begin
            o_rdata <= 32'h00000000;
        end
    end

endmodule // fer_resolver

// >>> tb/fer_dispatch_model.sv
// fault dispatch stand-in: counts faults and keeps the last kind taken
`timescale 1ns/1ps

module fer_dispatch_model
(
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_fault,
    input wire fer_pkg::fer_fault_t i_fault_kind,
    output logic [31:0] o_fault_count,
    output fer_pkg::fer_fault_t o_last_kind
);
    import fer_pkg::*;
    // a fault is a one-cycle pulse, so each high cycle is one dispatch
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
            o_fault_count <= 32'h0;
        else if (i_fault)
            o_fault_count <= o_fault_count + 32'h1;
    end
    // the kind is only meaningful beside the pulse
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
            o_last_kind <= FLT_NONE;
        else if (i_fault)
            o_last_kind <= i_fault_kind;
    end
endmodule // fer_dispatch_model

// >>> tb/fer_monitor.sv
// concurrent checks on the exception resolver ports
`timescale 1ns/1ps

module fer_monitor
(
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_op_valid,
    input wire fer_pkg::fer_fmt_t i_fmt,
    input wire logic i_div_zero,
    input wire logic i_f2i,
    input wire logic i_scale,
    input wire logic i_nonzero,
    input wire logic signed [fer_pkg::EXP_W-1:0] i_exp,
    input wire logic i_inexact,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic o_dest_we,
    input wire logic o_fault,
    input wire fer_pkg::fer_fault_t o_fault_kind,
    input wire logic o_rec_we,
    input wire logic [7:0] o_rec_flags
);
    import fer_pkg::*;
    logic [3:0] mask;
    // mirror of the mask field; only software writes can move it
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
            mask <= MASK_RESET;
        else if (i_wr && i_addr == ARITH_CTRL_OFS)
            mask <= i_wdata[11:8];
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    sequence s_op;
        i_op_valid && !i_div_zero && i_nonzero;
    endsequence
    sequence s_fault(fer_fault_t k);
        o_fault && o_fault_kind == k && !o_dest_we;
    endsequence
    a_zdiv_store: assert property (i_op_valid && i_div_zero && mask[0] |=> o_dest_we && !o_fault)
        else $error("masked zero-divide not stored");
    a_zdiv_fault: assert property (i_op_valid && i_div_zero && !mask[0] |=> s_fault(FLT_ZDIV))
        else $error("unmasked zero-divide not faulted");
    a_no_f2i_ovf: assert property (i_op_valid && i_f2i |=> o_fault_kind != FLT_OVF)
        else $error("overflow on float to integer");
    a_ovf_single: assert property (s_op ##0 !i_f2i && i_fmt == FMT_SINGLE && i_exp > SGL_EMAX && !mask[1]
        |=> s_fault(FLT_OVF) ##0 o_rec_we)
        else $error("single overflow missed");
    a_ovf_bias: assert property (s_op ##0 !i_f2i && !i_scale && i_fmt == FMT_EXT && i_exp > EXT_EMAX && !mask[1]
        |=> s_fault(FLT_OVF) ##0 o_rec_we && o_rec_flags[1])
        else $error("overflow bias flag missing");
    a_unf_bias: assert property (s_op ##0 !i_scale && i_fmt == FMT_EXT && i_exp < EXT_EMIN && !mask[2]
        |=> s_fault(FLT_UNF) ##0 o_rec_we && o_rec_flags[1])
        else $error("underflow bias flag missing");
    a_unf_exact: assert property (s_op ##0 i_fmt == FMT_SINGLE && i_exp < SGL_EMIN && mask[2] && !i_inexact
        |=> o_dest_we && !o_fault)
        else $error("exact denormal not stored");
    a_unf_inx: assert property (s_op ##0 i_fmt == FMT_SINGLE && i_exp < SGL_EMIN && mask[2] && i_inexact
        && !mask[3] |=> s_fault(FLT_INX) ##0 o_rec_we)
        else $error("tiny inexact fault missing");
    a_ovf_masked: assert property (s_op ##0 !i_f2i && i_fmt == FMT_SINGLE && i_exp > SGL_EMAX && mask[1]
        && mask[3] |=> o_dest_we && !o_fault)
        else $error("masked overflow not stored");
    a_inx_lone: assert property (s_op ##0 i_exp == 20'sh0 && i_inexact && !mask[3]
        |=> o_fault && o_fault_kind == FLT_INX && o_dest_we)
        else $error("lone inexact not stored and faulted");
endmodule // fer_monitor

bind fer_resolver fer_monitor fer_monitor_i (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_op_valid(i_op_valid),
    .i_fmt(i_fmt), .i_div_zero(i_div_zero), .i_f2i(i_f2i), .i_scale(i_scale), .i_nonzero(i_nonzero), .i_exp(i_exp),
    .i_inexact(i_inexact), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .o_dest_we(o_dest_we),
    .o_fault(o_fault), .o_fault_kind(o_fault_kind), .o_rec_we(o_rec_we), .o_rec_flags(o_rec_flags));

// >>> tb/fer_testbench.sv
// self-checking bench for the exception resolver
`timescale 1ns/1ps

module testbench;
    import fer_pkg::*;
    typedef struct packed {logic we; logic flt; fer_fault_t kind; logic [79:0] dv;} fer_exp_t;
    logic i_core_clk, i_rst_b, i_op_valid, i_div_zero, i_f2i, i_scale, i_nonzero, i_sign, i_inexact, i_wr, i_rd;
    logic o_done, o_dest_we, o_fault, o_rec_we, rd_d, sg;
    fer_fmt_t i_fmt;
    fer_fault_t o_fault_kind, last_kind;
    logic signed [19:0] i_exp;
    logic [63:0] i_sig;
    logic [79:0] i_dest_value, o_dest_value, o_rec_value;
    logic [7:0] i_addr, o_rec_flags;
    logic [31:0] i_wdata, o_rdata, fault_count;
    logic [1:0] o_round_mode;
    integer seed = 12;
    int mismatches = 0;
    int check_count = 0;
    int nflt = 0;
    fer_exp_t exp_q[$];
    logic [31:0] rd_q[$];
    fer_resolver fer_resolver_i (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_op_valid(i_op_valid),
        .i_fmt(i_fmt), .i_div_zero(i_div_zero), .i_f2i(i_f2i), .i_scale(i_scale), .i_nonzero(i_nonzero),
        .i_sign(i_sign), .i_exp(i_exp), .i_sig(i_sig), .i_inexact(i_inexact), .i_dest_value(i_dest_value),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_done(o_done),
        .o_dest_we(o_dest_we), .o_dest_value(o_dest_value), .o_fault(o_fault), .o_fault_kind(o_fault_kind),
        .o_rec_we(o_rec_we), .o_rec_value(o_rec_value), .o_rec_flags(o_rec_flags), .o_round_mode(o_round_mode));
    fer_dispatch_model fer_dispatch_model_i (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_fault(o_fault),
        .i_fault_kind(o_fault_kind), .o_fault_count(fault_count), .o_last_kind(last_kind));
    // 200 MHz core clock
    initial
    begin
        i_core_clk = 1'b0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end
    task automatic close_out();
        if (mismatches == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(logic [31:0] g, logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    // one datapath result; the expected answer is queued before the pulse
    task automatic op(fer_fmt_t f, logic dz, logic f2, logic sc, logic signed [19:0] e, logic ix,
        logic we, logic fl, fer_fault_t k);
        logic [79:0] dv;
        dv = {16'($random(seed)), 32'($random(seed)), 32'($random(seed))};
        @(posedge i_core_clk);
        sg = 1'($random(seed));
        i_sig <= {$random(seed), $random(seed)} | INF_SIG;
        i_op_valid <= 1'b1;
        i_fmt <= f;
        i_div_zero <= dz;
        i_f2i <= f2;
        i_scale <= sc;
        i_exp <= e;
        i_inexact <= ix;
        i_sign <= sg;
        i_dest_value <= dv;
        exp_q.push_back('{we, fl, fl ? k : FLT_NONE, dz ? SGL_INF | (80'(sg) << SGL_SIGN_BIT) : dv});
        nflt += int'(fl);
        @(posedge i_core_clk);
        i_op_valid <= 1'b0;
    endtask
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= w;
        i_rd <= !w;
        if (!w)
            rd_q.push_back(d);
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    always @(posedge i_core_clk)
        rd_d <= i_rd;
    // results are checked mid-cycle, once every registered output has settled
    always @(negedge i_core_clk)
    begin
        if (rd_d === 1'b1)
            chk(o_rdata, rd_q.pop_front());
        if (o_done === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk(32'h1, 32'h0);
            else
            begin
                fer_exp_t x;
                logic rw;
                x = exp_q.pop_front();
                // a record goes with every fault that suppresses the store, zero-divide aside
                rw = x.flt && !x.we && (x.kind != FLT_ZDIV);
                chk({o_dest_we, o_fault, o_rec_we, 26'h0, o_fault_kind}, {x.we, x.flt, rw, 26'h0, x.kind});
                // whole 80-bit value, not only its low word
                if (x.we)
                    chk(32'(|(o_dest_value ^ x.dv)), 32'h0);
            end
        end
    end
    // a hang is cut short here
    initial
    begin
        repeat (3000) @(posedge i_core_clk);
        mismatches++;
        close_out();
    end
    initial
    begin
        {i_rst_b, i_op_valid, i_div_zero, i_f2i, i_scale, i_sign, i_inexact, i_wr, i_rd} = '0;
        i_nonzero = 1'b1;
        {i_fmt, i_exp, i_sig, i_dest_value, i_addr, i_wdata} = '0;
        repeat (2) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        bus(0, ARITH_CTRL_OFS, 32'h00000F00);
        op(FMT_SINGLE, 1, 0, 0, 20'sd0, 0, 1, 0, FLT_NONE);
        bus(0, ARITH_CTRL_OFS, 32'h00000F01);
        bus(1, ARITH_CTRL_OFS, 32'h00030000);
        bus(0, ARITH_CTRL_OFS, 32'h00030000);
        chk(32'(o_round_mode), 32'h3);
        op(FMT_SINGLE, 1, 0, 0, 20'sd0, 0, 0, 1, FLT_ZDIV);
        // a zero result is never tiny, even with underflow unmasked
        i_nonzero <= 1'b0;
        op(FMT_SINGLE, 0, 0, 0, -20'sd130, 0, 1, 0, FLT_NONE);
        i_nonzero <= 1'b1;
        op(FMT_SINGLE, 0, 0, 0, 20'sd127, 0, 1, 0, FLT_NONE);
        op(FMT_DOUBLE, 0, 0, 0, 20'sd1024, 0, 0, 1, FLT_OVF);
        op(FMT_SINGLE, 0, 0, 0, 20'sd200, 0, 0, 1, FLT_OVF);
        bus(0, REC_LO_OFS, 32'h0);
        bus(0, REC_MID_OFS, i_sig[63:32] & 32'hFFFFFF00);
        bus(0, REC_HI_OFS, {16'h0000, sg, 15'h40C7});
        op(FMT_EXT, 0, 0, 0, 20'sd20000, 0, 0, 1, FLT_OVF);
        bus(0, REC_HI_OFS, {16'h0002, sg, 15'h2E1F});
        op(FMT_EXT, 0, 0, 0, -20'sd20000, 0, 0, 1, FLT_UNF);
        bus(0, REC_HI_OFS, {16'h0002, sg, 15'h51DF});
        op(FMT_EXT, 0, 0, 1, 20'sd400000, 0, 0, 1, FLT_OVF);
        bus(0, REC_MID_OFS, 32'h80000000);
        chk(o_rec_value[63:32], 32'h80000000);
        op(FMT_EXT, 0, 0, 1, -20'sd400000, 0, 0, 1, FLT_UNF);
        bus(0, REC_MID_OFS, 32'h0);
        op(FMT_SINGLE, 0, 1, 0, 20'sd200, 0, 1, 0, FLT_NONE);
        op(FMT_SINGLE, 0, 0, 0, 20'sd0, 1, 1, 1, FLT_INX);
        bus(0, ARITH_CTRL_OFS, 32'h00030000);
        bus(1, ARITH_CTRL_OFS, 32'h00000700);
        op(FMT_SINGLE, 0, 0, 0, -20'sd130, 1, 0, 1, FLT_INX);
        op(FMT_SINGLE, 0, 0, 0, 20'sd200, 0, 0, 1, FLT_INX);
        op(FMT_SINGLE, 0, 0, 0, -20'sd130, 0, 1, 0, FLT_NONE);
        bus(0, ARITH_CTRL_OFS, 32'h00000706);
        bus(1, ARITH_CTRL_OFS, 32'h00000F00);
        op(FMT_SINGLE, 0, 0, 0, -20'sd130, 1, 1, 0, FLT_NONE);
        op(FMT_SINGLE, 0, 0, 0, 20'sd200, 0, 1, 0, FLT_NONE);
        op(FMT_SINGLE, 0, 0, 0, 20'sd0, 0, 1, 0, FLT_NONE);
        bus(0, ARITH_CTRL_OFS, 32'h00000F0E);
        bus(0, 8'h14, 32'h0);
        bus(0, LAST_FAULT_OFS, 32'(FLT_INX));
        repeat (4) @(posedge i_core_clk);
        chk(32'(exp_q.size()), 32'h0);
        chk(fault_count, 32'(nflt));
        close_out();
    end
endmodule // testbench
